// ---- rtl/rdmux_ctrl.sv ----
// rdmux_ctrl: top of the redriver mux control, detection sequencing and output gating
//
// Operation
// - with enable low the part sits in standby and all redrivers are off.
// - channel one drives output A when its select is low and output B when high.
// - channel two takes input A when its select is low and input B when high.
// - deemphasis 00/01/10/11 gives 0 dB low swing, 0 dB full, 3.5 dB full, 6 dB full.
// - an output is in low swing only when both deemphasis bits are zero.
// - equalization msb low gives 0 dB, 10 gives 3.5 dB, 11 gives 6 dB, per input.
// - detection starts on enable rising and at power-up when enable is already high.
// - with enable high, any edge on the trigger or either select restarts detection.
// - while detection runs the part stays in standby with outputs squelched.
// - attempts repeat without limit on each channel until a receiver is found.
// - after one channel finds a receiver, at most 2^16 more attempts go to the other.
// - a detected channel gets its output driver and idle detection enabled.
// - with idle detection on, the output is squelched while input is below threshold.
`timescale 1ns/10ps
module rdmux_ctrl (
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  input  wire logic       enable,
  input  wire logic       ch1_output_path_select,
  input  wire logic       ch2_input_path_select,
  input  wire logic       receiver_detect_trigger,
  input  wire logic [1:0] ch1a_deemph_setting,
  input  wire logic [1:0] ch1b_deemph_setting,
  input  wire logic [1:0] ch2_deemph_setting,
  input  wire logic [1:0] ch1_equalization_setting,
  input  wire logic [1:0] ch2a_equalization_setting,
  input  wire logic [1:0] ch2b_equalization_setting,
  input  wire logic       ch1_receiver_present,
  input  wire logic       ch2_receiver_present,
  input  wire logic       ch1_input_above_idle,
  input  wire logic       ch2_input_above_idle,
  output logic            standby_r,
  output logic            detect_probe_r,
  output logic            ch1_rx_found_r,
  output logic            ch2_rx_found_r,
  output logic            ch1a_drive_en_r,
  output logic            ch1b_drive_en_r,
  output logic            ch2_drive_en_r,
  output logic            ch2_src_b_r,
  output logic            ch1_idle_det_en_r,
  output logic            ch2_idle_det_en_r,
  output rdmux_pkg::rdmux_drive_t ch1a_drive_r,
  output rdmux_pkg::rdmux_drive_t ch1b_drive_r,
  output rdmux_pkg::rdmux_drive_t ch2_drive_r,
  output logic [1:0]      ch1_eq_level_r,
  output logic [1:0]      ch2a_eq_level_r,
  output logic [1:0]      ch2b_eq_level_r
);
  rdmux_pkg::rdmux_ctrl_t ctrl_in;
  rdmux_pkg::rdmux_ctrl_t ctrl_s;
  logic                   en_rise;
  logic                   restart_edge;
  rdmux_pkg::rdmux_state_t state_r;
  rdmux_pkg::rdmux_state_t state_nxt;
  logic [15:0]            pace_cnt_r;
  logic                   attempt_tick;
  logic [16:0]            extra_cnt_r;
  logic                   powerup_r;
  logic                   start_det;
  logic                   ch1_found;
  logic                   ch2_found;
  logic                   both_done;
  logic                   ch1_hit;
  logic                   ch2_hit;
  logic                   budget_out;
  logic [1:0]             unused_eq;
  rdmux_pkg::rdmux_drive_t unused_drive;

  assign ctrl_in = '{enable: enable,
                     ch1_output_path_select: ch1_output_path_select,
                     ch2_input_path_select: ch2_input_path_select,
                     receiver_detect_trigger: receiver_detect_trigger};

  rdmux_sync u_sync (
    .mclk         (mclk),
    .sys_rst      (sys_rst),
    .ctrl_in      (ctrl_in),
    .ctrl_sync    (ctrl_s),
    .en_rise      (en_rise),
    .restart_edge (restart_edge)
  );

  // one decoder per output, each also decoding one input; no half left open
  rdmux_setting_dec u_dec_1a (
    .mclk (mclk), .sys_rst (sys_rst),
    .deemph_setting (ch1a_deemph_setting), .equalization_setting (ch1_equalization_setting),
    .drive_r (ch1a_drive_r), .eq_level_r (ch1_eq_level_r)
  );
  rdmux_setting_dec u_dec_1b (
    .mclk (mclk), .sys_rst (sys_rst),
    .deemph_setting (ch1b_deemph_setting), .equalization_setting (ch2a_equalization_setting),
    .drive_r (ch1b_drive_r), .eq_level_r (ch2a_eq_level_r)
  );
  rdmux_setting_dec u_dec_2 (
    .mclk (mclk), .sys_rst (sys_rst),
    .deemph_setting (ch2_deemph_setting), .equalization_setting (ch2b_equalization_setting),
    .drive_r (ch2_drive_r), .eq_level_r (ch2b_eq_level_r)
  );
  assign unused_eq    = 2'h0;
  assign unused_drive = '0;

  // power-up with enable already high counts as a start, caught once after reset
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      powerup_r <= 1'b1;
    end else if (ctrl_s.enable | en_rise) begin
      powerup_r <= 1'b0;
    end
  end

  assign start_det = ctrl_s.enable & (en_rise | restart_edge | powerup_r);

  // attempt pacing divider: one enable pulse per detection attempt
  always_ff @(posedge mclk) begin
    if (sys_rst || start_det || state_r != rdmux_pkg::ST_DETECT) begin
      pace_cnt_r <= 16'h0000;
    end else if (attempt_tick) begin
      pace_cnt_r <= 16'h0000;
    end else begin
      pace_cnt_r <= pace_cnt_r + rdmux_pkg::ATT_CNT_ONE;
    end
  end
  assign attempt_tick = (pace_cnt_r == 16'(rdmux_pkg::ATTEMPT_CYCLES - 1));

  assign ch1_found  = attempt_tick & ch1_receiver_present & ~ch1_rx_found_r;
  assign ch2_found  = attempt_tick & ch2_receiver_present & ~ch2_rx_found_r;
  assign budget_out = (ch1_rx_found_r ^ ch2_rx_found_r) & attempt_tick
                    & (extra_cnt_r == rdmux_pkg::EXTRA_ATT_MAX - rdmux_pkg::EXTRA_ONE);
  assign both_done  = (ch1_rx_found_r | ch1_found) & (ch2_rx_found_r | ch2_found);
  // a find in this cycle counts at once, so outputs open with the state change
  assign ch1_hit    = ch1_rx_found_r | ch1_found;
  assign ch2_hit    = ch2_rx_found_r | ch2_found;

  // sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      rdmux_pkg::ST_STANDBY: begin
        if (start_det) begin
          state_nxt = rdmux_pkg::ST_DETECT;
        end
      end
      rdmux_pkg::ST_DETECT: begin
        // keep retrying until both channels answer or the extra attempts after the first find run out
        if (both_done || budget_out) begin
          state_nxt = rdmux_pkg::ST_ACTIVE;
        end
      end
      rdmux_pkg::ST_ACTIVE: begin
        if (start_det) begin
          state_nxt = rdmux_pkg::ST_DETECT;
        end
      end
      default: state_nxt = rdmux_pkg::ST_STANDBY;
    endcase
    if (!ctrl_s.enable) begin
      state_nxt = rdmux_pkg::ST_STANDBY;
    end else if (start_det) begin
      state_nxt = rdmux_pkg::ST_DETECT;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_r <= rdmux_pkg::ST_STANDBY;
    end else begin
      state_r <= state_nxt;
    end
  end

  // found flags clear at each new start and with enable low; a start wins over a set in the same cycle
  always_ff @(posedge mclk) begin
    if (sys_rst || start_det || !ctrl_s.enable) begin
      ch1_rx_found_r <= 1'b0;
      ch2_rx_found_r <= 1'b0;
    end else if (state_r == rdmux_pkg::ST_DETECT) begin
      if (ch1_found) begin
        ch1_rx_found_r <= 1'b1;
      end
      if (ch2_found) begin
        ch2_rx_found_r <= 1'b1;
      end
    end
  end

  // attempts on the other channel once one is found, capped at 2^16
  always_ff @(posedge mclk) begin
    if (sys_rst || start_det || state_r != rdmux_pkg::ST_DETECT) begin
      extra_cnt_r <= rdmux_pkg::EXTRA_ZERO;
    end else if (attempt_tick && (ch1_rx_found_r ^ ch2_rx_found_r)) begin
      extra_cnt_r <= extra_cnt_r + rdmux_pkg::EXTRA_ONE;
    end
  end

  // probe strobe toward the analog detector, one cycle per attempt;
  // it stands in the same cycle as the result is sampled, still inside standby
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      detect_probe_r <= 1'b0;
    end else begin
      detect_probe_r <= (state_r == rdmux_pkg::ST_DETECT) & ~start_det
                      & (pace_cnt_r == 16'(rdmux_pkg::ATTEMPT_CYCLES - 2));
    end
  end

  // standby covers enable low and the whole detection window
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      standby_r <= 1'b1;
    end else begin
      standby_r <= (state_nxt != rdmux_pkg::ST_ACTIVE);
    end
  end

  // idle detection follows each channel's receiver result
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ch1_idle_det_en_r <= 1'b0;
      ch2_idle_det_en_r <= 1'b0;
    end else begin
      ch1_idle_det_en_r <= (state_nxt == rdmux_pkg::ST_ACTIVE) & ch1_hit;
      ch2_idle_det_en_r <= (state_nxt == rdmux_pkg::ST_ACTIVE) & ch2_hit;
    end
  end

  // drivers: active state, receiver found, input above idle, path chosen
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ch1a_drive_en_r <= 1'b0;
      ch1b_drive_en_r <= 1'b0;
      ch2_drive_en_r  <= 1'b0;
      ch2_src_b_r     <= 1'b0;
    end else begin
      ch1a_drive_en_r <= (state_nxt == rdmux_pkg::ST_ACTIVE) & ch1_hit
                       & ch1_input_above_idle & ~ctrl_s.ch1_output_path_select;
      ch1b_drive_en_r <= (state_nxt == rdmux_pkg::ST_ACTIVE) & ch1_hit
                       & ch1_input_above_idle & ctrl_s.ch1_output_path_select;
      ch2_drive_en_r  <= (state_nxt == rdmux_pkg::ST_ACTIVE) & ch2_hit
                       & ch2_input_above_idle;
      ch2_src_b_r     <= ctrl_s.ch2_input_path_select;
    end
  end
endmodule

// ---- common/rdmux_pkg.sv ----
// rdmux_pkg: shared constants and carrier types for the redriver mux control
package rdmux_pkg;

  // deemphasis setting codes (msb, lsb)
  localparam logic [1:0] DE_0DB_LOW   = 2'h0;
  localparam logic [1:0] DE_0DB_FULL  = 2'h1;
  localparam logic [1:0] DE_3P5DB     = 2'h2;
  localparam logic [1:0] DE_6DB       = 2'h3;

  // decoded level codes shared by deemphasis and equalization
  localparam logic [1:0] LVL_0DB      = 2'h0;
  localparam logic [1:0] LVL_3P5DB    = 2'h1;
  localparam logic [1:0] LVL_6DB      = 2'h2;

  // detection attempt pacing and the post-detect attempt budget
  localparam int         ATTEMPT_NS       = 1000;
  localparam int         CLK_PERIOD_NS    = 5;
  localparam int         ATTEMPT_CYCLES   = ATTEMPT_NS / CLK_PERIOD_NS;
  localparam int         EXTRA_ATTEMPTS   = 65536;
  localparam logic [16:0] EXTRA_ATT_MAX   = 17'h1_0000;
  localparam logic [15:0] ATT_CNT_ONE     = 16'h0001;
  localparam logic [16:0] EXTRA_ONE       = 17'h0_0001;
  localparam logic [16:0] EXTRA_ZERO      = 17'h0_0000;

  // control pins grouped as they arrive from straps or host logic
  typedef struct packed {
    logic       enable;
    logic       ch1_output_path_select;
    logic       ch2_input_path_select;
    logic       receiver_detect_trigger;
  } rdmux_ctrl_t;

  // per-output drive setting after decode
  typedef struct packed {
    logic       low_swing;
    logic [1:0] deemph_level;
  } rdmux_drive_t;

  // detection sequencer states
  typedef enum logic [1:0] {
    ST_STANDBY = 2'b00,
    ST_DETECT  = 2'b01,
    ST_ACTIVE  = 2'b10
  } rdmux_state_t;

endpackage

// ---- rtl/rdmux_sync.sv ----
// rdmux_sync: two-flop synchronisers plus edge detect for the control pins
`timescale 1ns/10ps
module rdmux_sync (
  input  wire logic                  mclk,
  input  wire logic                  sys_rst,
  input  wire rdmux_pkg::rdmux_ctrl_t ctrl_in,
  output rdmux_pkg::rdmux_ctrl_t     ctrl_sync,
  output logic                       en_rise,
  output logic                       restart_edge
);
  rdmux_pkg::rdmux_ctrl_t meta_r;
  rdmux_pkg::rdmux_ctrl_t sync_r;
  rdmux_pkg::rdmux_ctrl_t prev_r;

  // first stage feeds only the second; edges come from stages two and three
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= ctrl_in;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  assign ctrl_sync    = sync_r;
  assign en_rise      = sync_r.enable & ~prev_r.enable;
  // any edge on trigger or either select restarts detection
  assign restart_edge = (sync_r.receiver_detect_trigger ^ prev_r.receiver_detect_trigger)
                      | (sync_r.ch1_output_path_select ^ prev_r.ch1_output_path_select)
                      | (sync_r.ch2_input_path_select ^ prev_r.ch2_input_path_select);
endmodule

// ---- rtl/rdmux_setting_dec.sv ----
// rdmux_setting_dec: registered decode of deemphasis and equalization pins
`timescale 1ns/10ps
module rdmux_setting_dec (
  input  wire logic                 mclk,
  input  wire logic                 sys_rst,
  input  wire logic [1:0]           deemph_setting,
  input  wire logic [1:0]           equalization_setting,
  output rdmux_pkg::rdmux_drive_t   drive_r,
  output logic [1:0]                eq_level_r
);
  // deemphasis code to level; low swing only for code 00
  function automatic rdmux_pkg::rdmux_drive_t dec_deemph(input logic [1:0] code);
    rdmux_pkg::rdmux_drive_t d;
    d.low_swing = (code == rdmux_pkg::DE_0DB_LOW);
    case (code)
      rdmux_pkg::DE_3P5DB: d.deemph_level = rdmux_pkg::LVL_3P5DB;
      rdmux_pkg::DE_6DB:   d.deemph_level = rdmux_pkg::LVL_6DB;
      default:             d.deemph_level = rdmux_pkg::LVL_0DB;
    endcase
    return d;
  endfunction

  // equalization: msb low means 0 dB whatever the lsb says
  function automatic logic [1:0] dec_eq(input logic [1:0] code);
    logic [1:0] l;
    if (!code[1]) begin
      l = rdmux_pkg::LVL_0DB;
    end else if (code[0]) begin
      l = rdmux_pkg::LVL_6DB;
    end else begin
      l = rdmux_pkg::LVL_3P5DB;
    end
    return l;
  endfunction

  // static straps; registering keeps outputs glitch free
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      drive_r    <= '{low_swing: 1'b1, deemph_level: rdmux_pkg::LVL_0DB};
      eq_level_r <= rdmux_pkg::LVL_0DB;
    end else begin
      drive_r    <= dec_deemph(deemph_setting);
      eq_level_r <= dec_eq(equalization_setting);
    end
  end
endmodule

// ---- test/rdmux_ctrl_props.sv ----
// rdmux_ctrl_props: concurrent checks on the redriver mux control ports
`timescale 1ns/10ps
module rdmux_ctrl_props (
  input wire logic                    mclk,
  input wire logic                    sys_rst,
  input wire logic                    enable,
  input wire logic                    ch1_output_path_select,
  input wire logic                    ch2_input_path_select,
  input wire logic                    receiver_detect_trigger,
  input wire logic [1:0]              ch1a_deemph_setting,
  input wire logic [1:0]              ch2a_equalization_setting,
  input wire logic                    ch1_input_above_idle,
  input wire logic                    standby_r,
  input wire logic                    detect_probe_r,
  input wire logic                    ch1_rx_found_r,
  input wire logic                    ch1a_drive_en_r,
  input wire logic                    ch2_drive_en_r,
  input wire logic                    ch2_src_b_r,
  input wire logic                    ch1_idle_det_en_r,
  input wire rdmux_pkg::rdmux_drive_t ch1a_drive_r,
  input wire logic [1:0]              ch2a_eq_level_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // level code for a two-bit setting; msb low means no boost
  function automatic logic [1:0] lv(input logic [1:0] c);
    return c[1] ? (c[0] ? rdmux_pkg::LVL_6DB : rdmux_pkg::LVL_3P5DB) : rdmux_pkg::LVL_0DB;
  endfunction

  // margins of six cycles cover the two-flop sync plus the output register
  stby_enable_low_a: assert property (!enable [*6] |-> standby_r)
    else $error("standby missing with enable low");
  path_a_select_a: assert property (ch1_output_path_select [*6] |-> !ch1a_drive_en_r)
    else $error("output A driven with select high");
  src_b_select_a: assert property (ch2_input_path_select [*6] ##0 ch2_drive_en_r |-> ch2_src_b_r)
    else $error("channel two not sourced from B");
  deemph_decode_a: assert property ($stable(ch1a_deemph_setting) [*5]
    |-> ch1a_drive_r == {ch1a_deemph_setting == 2'h0, lv(ch1a_deemph_setting)})
    else $error("deemphasis decode wrong");
  eq_decode_a: assert property ($stable(ch2a_equalization_setting) [*5]
    |-> ch2a_eq_level_r == lv(ch2a_equalization_setting))
    else $error("equalization decode wrong");
  probe_standby_a: assert property (detect_probe_r |-> standby_r)
    else $error("probe outside standby");
  restart_clear_a: assert property (enable [*4] ##1 ($changed(receiver_detect_trigger) && enable)
    ##1 enable [*5] |-> standby_r && !ch1_rx_found_r)
    else $error("trigger edge did not restart detection");
  drive_found_a: assert property (ch1a_drive_en_r |-> ch1_rx_found_r && ch1_idle_det_en_r)
    else $error("output driven without a found receiver");
  idle_squelch_a: assert property (!ch1_input_above_idle [*6] |-> !ch1a_drive_en_r)
    else $error("output not squelched on idle input");
endmodule

bind rdmux_ctrl rdmux_ctrl_props props_u (.*);

// ---- test/rdmux_link_model.sv ----
// rdmux_link_model: far-side receivers answering the detection probes
`timescale 1ns/10ps
module rdmux_link_model (
  input  wire logic       mclk,
  input  wire logic       clr,
  input  wire logic       detect_probe_r,
  input  wire logic [3:0] ch1_need,
  input  wire logic [3:0] ch2_need,
  output logic            ch1_receiver_present,
  output logic            ch2_receiver_present,
  output logic [7:0]      probes
);
  // count attempts so a receiver can stay hidden for the first few
  always_ff @(posedge mclk) begin
    if (clr) probes <= 8'h00;
    else if (detect_probe_r) probes <= probes + 8'h01;
  end
  // a receiver answers only once enough attempts went by
  assign ch1_receiver_present = probes >= {4'h0, ch1_need};
  assign ch2_receiver_present = probes >= {4'h0, ch2_need};
endmodule

// ---- test/rdmux_ctrl_test.sv ----
// rdmux_ctrl_test: directed bench for the redriver mux control
`timescale 1ns/10ps
module rdmux_ctrl_test;
  logic mclk, sys_rst, enable, ch1_output_path_select, ch2_input_path_select, receiver_detect_trigger;
  logic ch1_receiver_present, ch2_receiver_present, ch1_input_above_idle, ch2_input_above_idle;
  logic [1:0] ch1a_deemph_setting, ch1b_deemph_setting, ch2_deemph_setting;
  logic [1:0] ch1_equalization_setting, ch2a_equalization_setting, ch2b_equalization_setting;
  logic standby_r, detect_probe_r, ch1_rx_found_r, ch2_rx_found_r, ch1a_drive_en_r, ch1b_drive_en_r;
  logic ch2_drive_en_r, ch2_src_b_r, ch1_idle_det_en_r, ch2_idle_det_en_r, clr;
  rdmux_pkg::rdmux_drive_t ch1a_drive_r, ch1b_drive_r, ch2_drive_r;
  logic [1:0] ch1_eq_level_r, ch2a_eq_level_r, ch2b_eq_level_r, de;
  logic [3:0] ch1_need, ch2_need;
  logic [7:0] probes;
  int failures, comparisons;

  rdmux_ctrl dut_u (.*);
  rdmux_link_model link_u (.mclk(mclk), .clr(clr), .detect_probe_r(detect_probe_r), .ch1_need(ch1_need),
    .ch2_need(ch2_need), .ch1_receiver_present(ch1_receiver_present),
    .ch2_receiver_present(ch2_receiver_present), .probes(probes));

  function automatic logic [1:0] lv(input logic [1:0] c);
    return c[1] ? (c[0] ? rdmux_pkg::LVL_6DB : rdmux_pkg::LVL_3P5DB) : rdmux_pkg::LVL_0DB;
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // bounded wait for detection to finish; attempts are 200 cycles apart
  task automatic wait_on();
    for (int i = 0; i < 3000 && standby_r !== 1'h0; i++) @(negedge mclk);
    chk(standby_r, 8'h00);
  endtask

  task automatic complete_run();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end

  // the whole run needs well under 10k cycles
  initial begin
    #100000;
    failures++;
    complete_run();
  end

  initial begin
    sys_rst = 1'h1; clr = 1'h1; enable = 1'h1; receiver_detect_trigger = 1'h0;
    ch1_output_path_select = 1'h0; ch2_input_path_select = 1'h0;
    ch1_input_above_idle = 1'h1; ch2_input_above_idle = 1'h1; ch1_need = 4'h3; ch2_need = 4'h1;
    {ch1a_deemph_setting, ch1b_deemph_setting, ch2_deemph_setting} = 6'h00;
    {ch1_equalization_setting, ch2a_equalization_setting, ch2b_equalization_setting} = 6'h00;
    cyc(4);
    sys_rst = 1'h0; clr = 1'h0;
    chk({standby_r, ch1a_drive_en_r, ch1b_drive_en_r, ch2_drive_en_r}, 8'h08);
    chk(ch1a_drive_r, 8'h04);
    $display("test reset done");
    // every setting code while the power-up detection runs
    for (int c = 0; c < 4; c++) begin
      de = 2'(c);
      {ch1a_deemph_setting, ch1b_deemph_setting, ch2_deemph_setting} = {3{de}};
      {ch1_equalization_setting, ch2a_equalization_setting, ch2b_equalization_setting} = {3{~de}};
      cyc(6);
      chk({ch1a_drive_r, ch1b_drive_r}, {2'h0, {2{de == 2'h0, lv(de)}}});
      chk(ch2_drive_r, {de == 2'h0, lv(de)});
      chk({ch1_eq_level_r, ch2a_eq_level_r, ch2b_eq_level_r}, {2'h0, {3{lv(~de)}}});
    end
    $display("test decode done");
    wait_on();
    chk(probes > 8'h02, 8'h01);
    chk({ch1_rx_found_r, ch2_rx_found_r, ch1a_drive_en_r, ch1b_drive_en_r, ch2_drive_en_r, ch2_src_b_r,
      ch1_idle_det_en_r, ch2_idle_det_en_r}, 8'heb);
    $display("test detect done");
    ch1_input_above_idle = 1'h0;
    cyc(8);
    chk({ch1a_drive_en_r, ch2_drive_en_r}, 8'h01);
    ch1_input_above_idle = 1'h1;
    cyc(8);
    chk(ch1a_drive_en_r, 8'h01);
    $display("test idle done");
    clr = 1'h1; ch1_need = 4'h0; ch2_need = 4'h0;
    cyc(1);
    clr = 1'h0; ch1_output_path_select = 1'h1; ch2_input_path_select = 1'h1;
    cyc(6);
    chk({standby_r, ch1_rx_found_r}, 8'h02);
    wait_on();
    chk({ch1a_drive_en_r, ch1b_drive_en_r, ch2_src_b_r}, 8'h03);
    chk(probes, 8'h01);
    $display("test select done");
    receiver_detect_trigger = 1'h1;
    cyc(6);
    chk(standby_r, 8'h01);
    wait_on();
    $display("test trigger done");
    enable = 1'h0;
    cyc(6);
    chk({standby_r, ch1a_drive_en_r, ch1b_drive_en_r, ch2_drive_en_r}, 8'h08);
    clr = 1'h1;
    cyc(1);
    clr = 1'h0; receiver_detect_trigger = 1'h0; ch1_output_path_select = 1'h0;
    cyc(300);
    chk(standby_r, 8'h01);
    chk(probes, 8'h00);
    enable = 1'h1;
    wait_on();
    chk(ch1a_drive_en_r, 8'h01);
    $display("test standby done");
    complete_run();
  end
endmodule
